// file: logic/bcsc_pkg.sv
// Constants, state codes and shared arithmetic for the charge state control.
// Assumes a 100 MHz clock; all currents are carried as 12-bit mA values.
package bcsc_pkg;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int TICK_PERIOD_NS   = 1_000_000_000;
  localparam int TICK_CYCLES      = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int AICL_STEP_NS     = 1_000_000;
  localparam int AICL_STEP_CYCLES = AICL_STEP_NS / CLK_PERIOD_NS;

  localparam int               MA_W  = 12;
  localparam int               TMR_W = 16;
  // Safety timer limits in one-second ticks
  localparam logic [TMR_W-1:0] PQ_TIME_S = 16'h0708;
  localparam logic [TMR_W-1:0] FC_TIME_S = 16'h5460;

  localparam logic [MA_W-1:0] ILIM_DEFAULT_MA = 12'hBB8;
  localparam logic [MA_W-1:0] ILIM_CUTOFF_MA  = 12'h032;
  localparam logic [MA_W-1:0] ILIM_STEP_MA    = 12'h019;
  localparam logic [MA_W-1:0] PRECHG_MA       = 12'h037;
  localparam logic [MA_W-1:0] TRICKLE_MA      = 12'h12C;
  localparam logic [MA_W-1:0] FC_RESET_MA     = 12'h3E8;
  localparam logic [MA_W-1:0] FOLD_STEP_MA    = 12'h019;

  localparam int             ADDR_W      = 4;
  localparam logic [3:0]     CTRL_ADDR   = 4'h0;
  localparam logic [3:0]     STATUS_ADDR = 4'h4;
  localparam logic [3:0]     ILIM_ADDR   = 4'h8;
  localparam int             ST_INOFF_BIT   = 8;
  localparam int             ST_REDUCED_BIT = 9;
  localparam int             ST_INOK_BIT    = 10;

  typedef enum logic [7:0] {
    ST_INIT    = 8'h01,
    ST_INHIBIT = 8'h02,
    ST_PRECHG  = 8'h04,
    ST_TRICKLE = 8'h08,
    ST_FASTCC  = 8'h10,
    ST_FASTCV  = 8'h20,
    ST_TFAULT  = 8'h40,
    ST_THERMAL_SHUTDOWN_THRESHOLD   = 8'h80
  } bcsc_state_t;

  function automatic logic [MA_W-1:0] satSub(input logic [MA_W-1:0] a,
                                             input logic [MA_W-1:0] b);
    satSub = (a > b) ? a - b : '0;
  endfunction : satSub

  function automatic logic [MA_W-1:0] minMa(input logic [MA_W-1:0] a,
                                            input logic [MA_W-1:0] b);
    minMa = (a < b) ? a : b;
  endfunction : minMa
endpackage : bcsc_pkg

// file: logic/bcsc_timer.sv
// Safety timer: prescaled one-second ticks counted against a limit.
// Assumes clear and run come from registered state in the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module bcsc_timer
  import bcsc_pkg::*;
#(
  parameter int TICK_N = TICK_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             clear,
  input  wire logic             run,
  input  wire logic [TMR_W-1:0] limit,
  output logic                  expired
);
  localparam int DW = $clog2(TICK_N + 1);

  logic [DW-1:0]    divCnt_ff;
  logic [TMR_W-1:0] secCnt_ff;
  logic             expired_ff;
  wire              tickNow = (divCnt_ff == DW'(TICK_N - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_ff  <= '0;
      secCnt_ff  <= '0;
      expired_ff <= 1'b0;
    end else if (clear || !run) begin
      divCnt_ff  <= '0;
      secCnt_ff  <= '0;
      expired_ff <= 1'b0;
    end else begin
      divCnt_ff  <= tickNow ? '0 : divCnt_ff + 1'b1;
      if (tickNow && secCnt_ff != '1) secCnt_ff <= secCnt_ff + 1'b1;
      expired_ff <= (secCnt_ff >= limit);
    end
  end
  assign expired = expired_ff;

  property p_clearZero;
    @(posedge clk) disable iff (!rstn) clear |=> !expired && secCnt_ff == '0;
  endproperty
  a_clearZero: assert property (p_clearZero) else $error("timer not cleared");
endmodule : bcsc_timer
`default_nettype wire

// file: logic/bcsc_ilim.sv
// Input current limit: source-based setting plus input-voltage regulation.
// Assumes comparator inputs are synchronous; also supplies the step tick.
`timescale 1ns/10ps
`default_nettype none
module bcsc_ilim
  import bcsc_pkg::*;
#(
  parameter int STEP_N = AICL_STEP_CYCLES
) (
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            chgValid,
  input  wire logic            detectDone,
  input  wire logic            srcKnown,
  input  wire logic [MA_W-1:0] srcLimitMa,
  input  wire logic            vinBelowReg,
  output logic      [MA_W-1:0] limitMa,
  output logic                 inputOn,
  output logic                 stepTick
);
  localparam int DW = $clog2(STEP_N + 1);

  logic [DW-1:0]   divCnt_ff;
  logic            tick_ff;
  logic            detDone_ff;
  logic [MA_W-1:0] limit_ff;
  logic            cut_ff;
  logic            inputOn_ff;

  wire [MA_W-1:0] baseMa  = srcKnown ? srcLimitMa : ILIM_DEFAULT_MA;
  wire            detEdge = detectDone && !detDone_ff;
  wire            atFloor = (limit_ff <= ILIM_CUTOFF_MA);
  wire [MA_W-1:0] downMa  = satSub(limit_ff, ILIM_STEP_MA);
  wire [MA_W-1:0] upMa    = minMa(baseMa, limit_ff + ILIM_STEP_MA);
  // Lowering never passes the cutoff, so the cut decision sees the floor
  wire [MA_W-1:0] nxt_limit = !chgValid ? ILIM_DEFAULT_MA :
                              detEdge ? baseMa :
                              (tick_ff && vinBelowReg && !atFloor) ?
                                ((downMa < ILIM_CUTOFF_MA) ? ILIM_CUTOFF_MA : downMa) :
                              (tick_ff && !vinBelowReg && limit_ff < baseMa) ? upMa :
                              limit_ff;
  // Cut latches until the input goes away and returns
  wire nxt_cut = chgValid && (cut_ff || (tick_ff && vinBelowReg && atFloor));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_ff  <= '0;
      tick_ff    <= 1'b0;
      detDone_ff <= 1'b0;
      limit_ff   <= ILIM_DEFAULT_MA;
      cut_ff     <= 1'b0;
      inputOn_ff <= 1'b0;
    end else begin
      divCnt_ff  <= (divCnt_ff == DW'(STEP_N - 1)) ? '0 : divCnt_ff + 1'b1;
      tick_ff    <= (divCnt_ff == DW'(STEP_N - 1));
      detDone_ff <= detectDone;
      limit_ff   <= nxt_limit;
      cut_ff     <= nxt_cut;
      inputOn_ff <= chgValid && !nxt_cut;
    end
  end
  assign limitMa  = limit_ff;
  assign inputOn  = inputOn_ff;
  assign stepTick = tick_ff;

  property p_cutAtFloor;
    @(posedge clk) disable iff (!rstn)
      $rose(cut_ff) |-> $past(limit_ff) == ILIM_CUTOFF_MA && $past(vinBelowReg) && !inputOn;
  endproperty
  a_cutAtFloor: assert property (p_cutAtFloor) else $error("input cut above cutoff");
endmodule : bcsc_ilim
`default_nettype wire

// file: logic/bcsc_top.sv
// Charge state control: input limit, charge state machine, safety timers.
// Assumes synchronous comparator levels and a plain register port master.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module bcsc_top
  import bcsc_pkg::*;
#(
  parameter int               TICK_N     = TICK_CYCLES,
  parameter int               STEP_N     = AICL_STEP_CYCLES,
  parameter logic [TMR_W-1:0] PQ_LIMIT_S = PQ_TIME_S,
  parameter logic [TMR_W-1:0] FC_LIMIT_S = FC_TIME_S
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  input  wire logic              chgValid,
  input  wire logic              switcherStarted,
  input  wire logic              timerSuspend,
  input  wire logic              detectDone,
  input  wire logic              srcKnown,
  input  wire logic [MA_W-1:0]   srcLimitMa,
  input  wire logic              vinBelowReg,
  input  wire logic              inhibitPinHigh,
  input  wire logic              supplementMode,
  input  wire logic              vbatAbovePrechg,
  input  wire logic              vbatAboveTrickle,
  input  wire logic              vbatAboveReg,
  input  wire logic              dieAboveReg,
  input  wire logic              dieAboveShdn,
  output logic                   inputOkN,
  output logic                   inputSwitchOn,
  output logic      [MA_W-1:0]   inputLimitMa,
  output logic      [MA_W-1:0]   chargeMa,
  output logic                   batterySwitchOn,
  output logic                   chargerOn,
  output logic                   statusOut,
  output logic                   statusOe,
  output logic      [7:0]        chargeState
);
  bcsc_state_t     state_ff;
  bcsc_state_t     nxt_state;
  logic [1:0]      grpPrev_ff;
  logic [MA_W-1:0] fcCfg_ff;
  logic [MA_W-1:0] fold_ff;
  logic [MA_W-1:0] chargeMa_ff;
  logic            inputOkN_ff;
  logic            batSw_ff;
  logic            chgOn_ff;
  logic            statOe_ff;
  logic [31:0]     rdata_ff;
  logic            stepTick;
  logic            timerRaw;

  // Timed groups: 1 prequalification, 2 fast charge
  function automatic logic [1:0] stGroup(input bcsc_state_t s);
    stGroup = (s == ST_PRECHG || s == ST_TRICKLE) ? 2'h1 :
              (s == ST_FASTCC || s == ST_FASTCV)  ? 2'h2 : 2'h0;
  endfunction : stGroup

  // Entry point chosen from battery level alone
  function automatic bcsc_state_t qualify(input logic aboveP, input logic aboveT,
                                          input logic aboveR);
    qualify = !aboveP ? ST_PRECHG : !aboveT ? ST_TRICKLE :
              !aboveR ? ST_FASTCC : ST_FASTCV;
  endfunction : qualify

  wire [1:0] curGrp     = stGroup(state_ff);
  wire       timerClear = (state_ff == ST_INIT) || (curGrp != grpPrev_ff);
  // Expiry left over from the group just left must not fault the new one
  wire       timerExpired = timerRaw && !timerClear;
  wire [TMR_W-1:0] timerLimit = (curGrp == 2'h1) ? PQ_LIMIT_S : FC_LIMIT_S;
  wire       goInit     = !chgValid || timerSuspend;
  wire       goInhibit  = chgValid && !inhibitPinHigh;
  wire       resumeSt   = inhibitPinHigh;
  wire bcsc_state_t entrySt = qualify(vbatAbovePrechg, vbatAboveTrickle, vbatAboveReg);

  bcsc_ilim #(
    .STEP_N (STEP_N)
  ) u_ilim (
    .clk         (clk),
    .rstn        (rstn),
    .chgValid    (chgValid),
    .detectDone  (detectDone),
    .srcKnown    (srcKnown),
    .srcLimitMa  (srcLimitMa),
    .vinBelowReg (vinBelowReg),
    .limitMa     (inputLimitMa),
    .inputOn     (inputSwitchOn),
    .stepTick    (stepTick)
  );

  bcsc_timer #(
    .TICK_N (TICK_N)
  ) u_timer (
    .clk     (clk),
    .rstn    (rstn),
    .clear   (timerClear),
    .run     (curGrp != 2'h0),
    .limit   (timerLimit),
    .expired (timerRaw)
  );

  always_comb begin
    nxt_state = state_ff;
    if (dieAboveShdn) begin
      nxt_state = ST_THERMAL_SHUTDOWN_THRESHOLD;
    end else if (state_ff == ST_THERMAL_SHUTDOWN_THRESHOLD) begin
      nxt_state = ST_INIT;
    end else if (goInit) begin
      nxt_state = ST_INIT;
    end else if (goInhibit) begin
      nxt_state = ST_INHIBIT;
    end else begin
      unique case (state_ff)
        ST_INIT:    nxt_state = entrySt;
        ST_INHIBIT: nxt_state = resumeSt ? entrySt : ST_INHIBIT;
        ST_PRECHG: begin
          if (timerExpired) nxt_state = ST_TFAULT;
          else if (vbatAbovePrechg) nxt_state = ST_TRICKLE;
        end
        ST_TRICKLE: begin
          if (timerExpired) nxt_state = ST_TFAULT;
          else if (!vbatAbovePrechg) nxt_state = ST_PRECHG;
          else if (vbatAboveTrickle) nxt_state = ST_FASTCC;
        end
        ST_FASTCC: begin
          if (timerExpired) nxt_state = ST_TFAULT;
          else if (!vbatAbovePrechg) nxt_state = ST_PRECHG;
          else if (vbatAboveReg) nxt_state = ST_FASTCV;
        end
        ST_FASTCV:  nxt_state = timerExpired ? ST_TFAULT : ST_FASTCV;
        ST_TFAULT:  nxt_state = ST_TFAULT;
        ST_THERMAL_SHUTDOWN_THRESHOLD:   nxt_state = ST_INIT;
      endcase
    end
  end

  // Foldback grows while hot in ST_FASTCC only, holds while hot elsewhere, relaxes once cool
  wire [MA_W-1:0] nxt_fold =
    !stepTick ? fold_ff :
    (dieAboveReg && state_ff == ST_FASTCC) ? minMa(fcCfg_ff, fold_ff + FOLD_STEP_MA) :
    dieAboveReg ? fold_ff : satSub(fold_ff, FOLD_STEP_MA);
  wire [MA_W-1:0] fastMa = satSub(fcCfg_ff, fold_ff);
  // Target is capped by the input limit in trickle and fast charge; precharge current is not
  wire [MA_W-1:0] targetMa =
    (state_ff == ST_PRECHG)  ? PRECHG_MA :
    (state_ff == ST_TRICKLE) ? minMa(TRICKLE_MA, inputLimitMa) :
    (state_ff == ST_FASTCC || state_ff == ST_FASTCV) ?
      minMa(fastMa, inputLimitMa) : '0;
  wire charging   = (curGrp != 2'h0);
  wire nxt_batSw  = charging || (state_ff == ST_INIT) ||
                    (state_ff == ST_INHIBIT && supplementMode);
  wire reduced    = vinBelowReg || dieAboveReg || (inputLimitMa < ILIM_DEFAULT_MA);
  wire ctrlWr     = wr && (addr == CTRL_ADDR);
  wire [31:0] statusWord = {21'h00000, !inputOkN_ff, reduced, !inputSwitchOn, state_ff};
  wire [31:0] readMux =
    (addr == CTRL_ADDR)   ? {20'h00000, fcCfg_ff} :
    (addr == STATUS_ADDR) ? statusWord :
    (addr == ILIM_ADDR)   ? {20'h00000, inputLimitMa} : 32'h00000000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= ST_INIT;
      grpPrev_ff  <= 2'h0;
      fcCfg_ff    <= FC_RESET_MA;
      fold_ff     <= '0;
      chargeMa_ff <= '0;
      inputOkN_ff <= 1'b1;
      batSw_ff    <= 1'b0;
      chgOn_ff    <= 1'b0;
      statOe_ff   <= 1'b0;
      rdata_ff    <= 32'h00000000;
    end else begin
      state_ff    <= nxt_state;
      grpPrev_ff  <= curGrp;
      fold_ff     <= nxt_fold;
      chargeMa_ff <= targetMa;
      inputOkN_ff <= !(switcherStarted && chgValid);
      batSw_ff    <= nxt_batSw;
      chgOn_ff    <= charging;
      statOe_ff   <= charging;
      rdata_ff    <= rd ? readMux : 32'h00000000;
      if (ctrlWr) fcCfg_ff <= wdata[MA_W-1:0];
    end
  end

  assign rdata           = rdata_ff;
  assign inputOkN        = inputOkN_ff;
  assign chargeMa        = chargeMa_ff;
  assign batterySwitchOn = batSw_ff;
  assign chargerOn       = chgOn_ff;
  assign statusOut       = 1'b0;
  assign statusOe        = statOe_ff;
  assign chargeState     = state_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_normal;
    chgValid && !timerSuspend && !dieAboveShdn && inhibitPinHigh;
  endsequence

  property p_shutdown;
    dieAboveShdn |=> state_ff == ST_THERMAL_SHUTDOWN_THRESHOLD ##1 !chargerOn;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("no thermal shutdown");

  property p_toInit;
    (!chgValid || timerSuspend) && !dieAboveShdn && state_ff != ST_THERMAL_SHUTDOWN_THRESHOLD
      |=> state_ff == ST_INIT;
  endproperty
  a_toInit: assert property (p_toInit) else $error("init not entered");

  property p_initOut;
    state_ff == ST_INIT |=> chargeMa == '0 && batterySwitchOn && !chargerOn;
  endproperty
  a_initOut: assert property (p_initOut) else $error("init outputs wrong");

  property p_inhibit;
    chgValid && !inhibitPinHigh && !timerSuspend && !dieAboveShdn && state_ff != ST_THERMAL_SHUTDOWN_THRESHOLD
      |=> state_ff == ST_INHIBIT ##1 batterySwitchOn == $past(supplementMode);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit not honoured");

  property p_preToTrickle;
    state_ff == ST_PRECHG && vbatAbovePrechg && !timerExpired ##0 s_normal
      |=> state_ff == ST_TRICKLE;
  endproperty
  a_preToTrickle: assert property (p_preToTrickle) else $error("precharge stuck");

  property p_precurrent;
    state_ff == ST_PRECHG |=> chargeMa == PRECHG_MA;
  endproperty
  a_precurrent: assert property (p_precurrent) else $error("precharge current wrong");

  property p_timeout;
    timerExpired && charging ##0 s_normal |=> state_ff == ST_TFAULT ##1 !statusOe && !chargerOn;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timer fault missed");

  property p_faultHold;
    state_ff == ST_TFAULT ##0 s_normal |=> state_ff == ST_TFAULT;
  endproperty
  a_faultHold: assert property (p_faultHold) else $error("fault left early");

  property p_inputOk;
    !inputOkN |-> $past(switcherStarted) && $past(chgValid);
  endproperty
  a_inputOk: assert property (p_inputOk) else $error("input-ok without cause");

  property p_trickleCap;
    state_ff == ST_TRICKLE |=> chargeMa <= TRICKLE_MA;
  endproperty
  a_trickleCap: assert property (p_trickleCap) else $error("trickle current too high");

  property p_ccToCv;
    state_ff == ST_FASTCC && vbatAboveReg && vbatAbovePrechg && !timerExpired ##0 s_normal
      |=> state_ff == ST_FASTCV;
  endproperty
  a_ccToCv: assert property (p_ccToCv) else $error("constant voltage not entered");

  property p_resume;
    state_ff == ST_INHIBIT ##0 s_normal |=> state_ff != ST_INHIBIT;
  endproperty
  a_resume: assert property (p_resume) else $error("inhibit not left");
endmodule : bcsc_top
`default_nettype wire

// file: verif/bcsc_mcu_model.sv
// Behavioural external controller that drives the charge-inhibit pin.
// Assumes the bench requests inhibit as a level; the pin moves only on input-ok.
`timescale 1ns/10ps
`default_nettype none
module bcsc_mcu_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic inputOkN,
  input  wire logic wantInhibit,
  output logic      inhibitPinHigh
);
  // Pin held while input-ok is absent, so a request may lag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inhibitPinHigh <= 1'b1;
    end else if (!inputOkN) begin
      inhibitPinHigh <= !wantInhibit;
    end
  end
endmodule : bcsc_mcu_model
`default_nettype wire

// file: verif/tb_battery_charge_state_control.sv
// Self-checking bench for the charge state control top level.
// Assumes shortened tick, step and timer parameters; controller model on the pin.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin badCount++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_battery_charge_state_control;
  import bcsc_pkg::*;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0]       wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [31:0]       rdata;
  logic              chgValid = 1'b0;
  logic              switcherStarted = 1'b1;
  logic              timerSuspend = 1'b0;
  logic              detectDone = 1'b0;
  logic              srcKnown = 1'b0;
  logic [MA_W-1:0]   srcLimitMa = 12'h7BC;
  logic              vinBelowReg = 1'b0;
  logic              inhibitPinHigh;
  logic              wantInhibit = 1'b0;
  logic              supplementMode = 1'b0;
  logic              vbatAbovePrechg = 1'b0;
  logic              vbatAboveTrickle = 1'b0;
  logic              vbatAboveReg = 1'b0;
  logic              dieAboveReg = 1'b0;
  logic              dieAboveShdn = 1'b0;
  logic              inputOkN, inputSwitchOn, batterySwitchOn, chargerOn;
  logic              statusOut, statusOe;
  logic [MA_W-1:0]   inputLimitMa, chargeMa;
  logic [7:0]        chargeState;
  int                badCount = 0;
  int                checked = 0;

  always #5 clk = ~clk;

  bcsc_top #(.TICK_N(4), .STEP_N(4), .PQ_LIMIT_S(16'h0003), .FC_LIMIT_S(16'h000A)) dut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .chgValid(chgValid), .switcherStarted(switcherStarted), .timerSuspend(timerSuspend),
    .detectDone(detectDone), .srcKnown(srcKnown), .srcLimitMa(srcLimitMa),
    .vinBelowReg(vinBelowReg), .inhibitPinHigh(inhibitPinHigh),
    .supplementMode(supplementMode), .vbatAbovePrechg(vbatAbovePrechg),
    .vbatAboveTrickle(vbatAboveTrickle), .vbatAboveReg(vbatAboveReg),
    .dieAboveReg(dieAboveReg), .dieAboveShdn(dieAboveShdn), .inputOkN(inputOkN),
    .inputSwitchOn(inputSwitchOn), .inputLimitMa(inputLimitMa), .chargeMa(chargeMa),
    .batterySwitchOn(batterySwitchOn), .chargerOn(chargerOn), .statusOut(statusOut),
    .statusOe(statusOe), .chargeState(chargeState));

  bcsc_mcu_model mcu (.clk(clk), .rstn(rstn), .inputOkN(inputOkN),
    .wantInhibit(wantInhibit), .inhibitPinHigh(inhibitPinHigh));

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Bounded poll, so a stuck machine shows as a mismatch, not a hang
  task automatic waitState(input logic [7:0] e, input int n);
    int i;
    for (i = 0; i < n && chargeState !== e; i++) @(negedge clk);
    `CHK("chargeState", e, chargeState)
  endtask : waitState

  task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk) begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
  endtask : regWrite

  task automatic regRead(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk) begin
      addr <= a;
      rd <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) d = rdata;
  endtask : regRead

  task automatic endTest(input string nm);
    $display("test %s finished", nm);
  endtask : endTest

  task automatic completeRun;
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : completeRun

  task automatic resetTest;
    logic [31:0] d;
    `CHK("chargeState", 8'h01, chargeState)
    `CHK("inputOkN", 1'b1, inputOkN)
    `CHK("inputLimitMa", ILIM_DEFAULT_MA, inputLimitMa)
    regRead(CTRL_ADDR, d);
    `CHK("ctrl", FC_RESET_MA, d[MA_W-1:0])
    regWrite(CTRL_ADDR, 32'hFFFF_F7D0);
    regWrite(STATUS_ADDR, 32'h0000_0000);
    regRead(CTRL_ADDR, d);
    `CHK("ctrl", 32'h0000_07D0, d)
    regRead(4'hC, d);
    `CHK("unmapped", 32'h0000_0000, d)
    endTest("reset");
  endtask : resetTest

  task automatic initTest;
    cyc(3);
    `CHK("chargeState", 8'h01, chargeState)
    `CHK("chargeMa", 12'h000, chargeMa)
    `CHK("batterySwitchOn", 1'b1, batterySwitchOn)
    `CHK("inputOkN", 1'b1, inputOkN)
    @(posedge clk) chgValid <= 1'b1;
    waitState(ST_PRECHG, 5);
    cyc(2);
    `CHK("chargeMa", PRECHG_MA, chargeMa)
    `CHK("inputOkN", 1'b0, inputOkN)
    endTest("init");
  endtask : initTest

  task automatic ladderTest;
    logic [31:0] d;
    @(posedge clk) vbatAbovePrechg <= 1'b1;
    waitState(ST_TRICKLE, 5);
    cyc(2);
    `CHK("chargeMa", TRICKLE_MA, chargeMa)
    @(posedge clk) vbatAboveTrickle <= 1'b1;
    waitState(ST_FASTCC, 5);
    @(posedge clk) begin
      srcKnown <= 1'b1;
      detectDone <= 1'b1;
    end
    cyc(5);
    `CHK("inputLimitMa", 12'h7BC, inputLimitMa)
    `CHK("chargeMa", 12'h7BC, chargeMa)
    regRead(STATUS_ADDR, d);
    `CHK("statusState", 8'h10, d[7:0])
    `CHK("statusInok", 1'b1, d[ST_INOK_BIT])
    `CHK("statusReduced", 1'b1, d[ST_REDUCED_BIT])
    `CHK("statusInOff", 1'b0, d[ST_INOFF_BIT])
    regRead(ILIM_ADDR, d);
    `CHK("ilim", 32'h0000_07BC, d)
    @(posedge clk) dieAboveReg <= 1'b1;
    cyc(8);
    `CHK("foldback", 1'b1, chargeMa < 12'h7BC)
    @(posedge clk) begin
      dieAboveReg <= 1'b0;
      vbatAboveReg <= 1'b1;
    end
    waitState(ST_FASTCV, 5);
    endTest("ladder");
  endtask : ladderTest

  task automatic suspendTest;
    @(posedge clk) begin
      vbatAbovePrechg <= 1'b0;
      vbatAboveTrickle <= 1'b0;
      vbatAboveReg <= 1'b0;
      timerSuspend <= 1'b1;
    end
    waitState(ST_INIT, 5);
    cyc(2);
    `CHK("chargeMa", 12'h000, chargeMa)
    @(posedge clk) timerSuspend <= 1'b0;
    waitState(ST_PRECHG, 5);
    endTest("suspend");
  endtask : suspendTest

  task automatic inhibitTest;
    @(posedge clk) wantInhibit <= 1'b1;
    waitState(ST_INHIBIT, 6);
    cyc(2);
    `CHK("batterySwitchOn", 1'b0, batterySwitchOn)
    @(posedge clk) supplementMode <= 1'b1;
    cyc(3);
    `CHK("batterySwitchOn", 1'b1, batterySwitchOn)
    @(posedge clk) begin
      supplementMode <= 1'b0;
      wantInhibit <= 1'b0;
    end
    waitState(ST_PRECHG, 6);
    cyc(2);
    `CHK("chargerOn", 1'b1, chargerOn)
    endTest("inhibit");
  endtask : inhibitTest

  task automatic faultTest;
    cyc(8);
    `CHK("chargeState", 8'h04, chargeState)
    waitState(ST_TFAULT, 30);
    cyc(2);
    `CHK("statusOe", 1'b0, statusOe)
    `CHK("chargerOn", 1'b0, chargerOn)
    `CHK("statusOut", 1'b0, statusOut)
    @(posedge clk) vbatAbovePrechg <= 1'b1;
    cyc(4);
    `CHK("chargeState", 8'h40, chargeState)
    @(posedge clk) chgValid <= 1'b0;
    waitState(ST_INIT, 5);
    @(posedge clk) chgValid <= 1'b1;
    waitState(ST_TRICKLE, 5);
    @(posedge clk) vbatAboveTrickle <= 1'b1;
    waitState(ST_FASTCC, 5);
    cyc(20);
    `CHK("chargeState", 8'h10, chargeState)
    waitState(ST_TFAULT, 60);
    endTest("fault");
  endtask : faultTest

  task automatic shdnTest;
    @(posedge clk) dieAboveShdn <= 1'b1;
    waitState(ST_THERMAL_SHUTDOWN_THRESHOLD, 5);
    cyc(2);
    `CHK("chargerOn", 1'b0, chargerOn)
    @(posedge clk) chgValid <= 1'b0;
    cyc(4);
    `CHK("chargeState", 8'h80, chargeState)
    @(posedge clk) dieAboveShdn <= 1'b0;
    waitState(ST_INIT, 5);
    endTest("shutdown");
  endtask : shdnTest

  task automatic aiclTest;
    int i;
    @(posedge clk) begin
      detectDone <= 1'b0;
      srcKnown <= 1'b0;
      chgValid <= 1'b1;
    end
    cyc(2);
    @(posedge clk) detectDone <= 1'b1;
    cyc(5);
    `CHK("inputLimitMa", 12'hBB8, inputLimitMa)
    `CHK("inputSwitchOn", 1'b1, inputSwitchOn)
    @(posedge clk) vinBelowReg <= 1'b1;
    for (i = 0; i < 700 && inputSwitchOn !== 1'b0; i++) @(negedge clk);
    `CHK("inputSwitchOn", 1'b0, inputSwitchOn)
    `CHK("inputLimitMa", ILIM_CUTOFF_MA, inputLimitMa)
    @(posedge clk) switcherStarted <= 1'b0;
    cyc(2);
    `CHK("inputOkN", 1'b1, inputOkN)
    endTest("aicl");
  endtask : aiclTest

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    resetTest();
    initTest();
    ladderTest();
    suspendTest();
    inhibitTest();
    faultTest();
    shdnTest();
    aiclTest();
    completeRun();
  end

  // Whole run needs about 700 cycles
  initial begin
    #100us;
    badCount++;
    $display("watchdog expired");
    completeRun();
  end
endmodule : tb_battery_charge_state_control
`undef CHK
`default_nettype wire
